// [logic/tvu_top.sv]
// trap and vector unit: source mapping, reset entry and trap detection
// Operation
// (RULE1) source n uses vector n plus eight; source 0 is vector 8.
// (RULE2) second and third external requests sit at sources 16 and 17.
// (RULE3) power pwm special event and four generators take sources 18 to 22.
// (RULE4) six converter pair done requests take sources 37 to 42.
// (RULE5) any reset skips interrupts, clears state, fetches from address zero.
// (RULE6) watchdog, lockout and other error sources route to the reset vector.
// (RULE7) uninitialised working register used as pointer forces reset.
// (RULE8) illegal opcode only counts when executed, not when flushed.
// (RULE9) several simultaneous traps force a reset.
// (RULE10) traps unmaskable, levels 8 to 15, top priority bit set.
// (RULE11) priority 0111 outside a trap blocks interrupts, still takes traps.
// (RULE12) offending instruction completes before trap processing starts.
// (RULE13) taking a vector holding an invalid address raises address error.
// (RULE14) traps may nest; ordering only matters for concurrent pending ones.
// (RULE15) divide by zero aborts the divide and takes math error.
// (RULE16) enabled accumulator overflow bit 31 or bit 39 takes math error.
// (RULE17) too large shift amount takes math error.
// (RULE18) misaligned word, unimplemented data or program access: address error.
// (RULE19) fetch from vector space or jump to unimplemented memory: address error.
// (RULE20) in dual space mac, other space counts as unimplemented.
// (RULE21) stack pointer above limit or below 0x0800 takes stack error.
// (RULE22) equal priority requests served lowest source number first.
// (RULE23) vector table spans 0x000004 to 0x0000FE, 24-bit handler addresses.
// (RULE24) reserved source numbers never request.
// (RULE25) trap handler address fetched from vector of its fixed level.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module tvu_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // peripheral requests
  input  wire logic        ext_request_0_i,
  input  wire logic        ext_request_1_i,
  input  wire logic        ext_request_2_i,
  input  wire logic [4:0]  pwm_event_i,
  input  wire logic [5:0]  pair_done_i,
  input  wire logic [53:0] other_req_i,
  input  wire logic [161:0] src_level_i,
  // core status
  input  wire logic        instr_done_i,
  input  wire logic [3:0]  cpu_priority_level_i,
  input  wire logic        div_zero_i,
  input  wire logic        acc_carry31_i,
  input  wire logic        acc_carry39_i,
  input  wire logic        shift_too_big_i,
  input  wire logic        data_misaligned_i,
  input  wire logic        data_unimpl_i,
  input  wire logic        prog_data_unimpl_i,
  input  wire logic        mac_dual_i,
  input  wire logic        mac_cross_space_i,
  input  wire logic        fetch_valid_i,
  input  wire logic [23:0] fetch_addr_i,
  input  wire logic        vector_fetch_i,
  input  wire logic [23:0] prog_limit_i,
  input  wire logic        sp_load_i,
  input  wire logic [15:0] sp_value_i,
  input  wire logic        handler_valid_i,
  input  wire logic [23:0] handler_addr_i,
  // reset sources
  input  wire logic        watchdog_timeout_i,
  input  wire logic        uninit_w_ptr_i,
  input  wire logic        illegal_op_exec_i,
  input  wire logic        illegal_op_flushed_i,
  // results
  output logic             irq_o,
  output logic [6:0]       irq_vector_o,
  output logic [3:0]       irq_level_o,
  output logic             trap_o,
  output logic [3:0]       trap_level_o,
  output logic [23:0]      trap_vec_addr_o,
  output logic             trap_priority_bit_o,
  output logic             core_reset_o,
  output logic [23:0]      reset_pc_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0]            ctrl;
  logic [15:0]            stack_limit_value;
  logic [3:0]             err_sticky;
  logic [53:0]            req_map;
  logic                   res_any;
  logic [5:0]             res_src;
  logic [2:0]             res_lvl;
  logic                   math_err;
  logic                   addr_err;
  logic                   stack_err;
  logic                   math_pend;
  logic                   addr_pend;
  logic                   stack_pend;
  logic                   in_trap;
  logic [3:0]             cur_trap_lvl;
  logic                   lockout;
  logic                   next_reset;
  tvu_pkg::tvu_state_e    state;

  ////////////////////////////////////////////////////////////////////////
  // source map
  always_comb begin
    req_map = other_req_i;
    req_map[tvu_pkg::SRC_EXT0] = ext_request_0_i;
    req_map[tvu_pkg::SRC_EXT1] = ext_request_1_i; // (RULE2)
    req_map[tvu_pkg::SRC_EXT2] = ext_request_2_i; // (RULE2)
    for (int i = 0; i < 5; i++) begin
      req_map[tvu_pkg::SRC_PWM_FIRST + i[5:0]] = pwm_event_i[i]; // (RULE3)
    end
    for (int i = 0; i < 6; i++) begin
      req_map[tvu_pkg::SRC_PAIR_FIRST + i[5:0]] = pair_done_i[i]; // (RULE4)
    end
  end

  tvu_src_resolver u_res (
    .req_i (req_map),
    .lvl_i (src_level_i),
    .any_o (res_any),
    .src_o (res_src),
    .lvl_o (res_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // trap detection
  always_comb begin
    math_err = div_zero_i // (RULE15)
             | (ctrl[tvu_pkg::CTRL_OV_EN] & acc_carry31_i & ~ctrl[tvu_pkg::CTRL_GUARD_USE]) // (RULE16)
             | (ctrl[tvu_pkg::CTRL_COV_EN] & acc_carry39_i & ~ctrl[tvu_pkg::CTRL_SAT_EN]) // (RULE16)
             | shift_too_big_i; // (RULE17)
    addr_err = data_misaligned_i | data_unimpl_i | prog_data_unimpl_i // (RULE18)
             | (mac_dual_i & mac_cross_space_i) // (RULE20)
             | (fetch_valid_i & ~vector_fetch_i & fetch_addr_i >= tvu_pkg::VT_FIRST
                & fetch_addr_i <= tvu_pkg::VT_LAST) // (RULE19)
             | (fetch_valid_i & fetch_addr_i > prog_limit_i) // (RULE19)
             | (handler_valid_i & (handler_addr_i > prog_limit_i
                | handler_addr_i <= tvu_pkg::VT_LAST)); // (RULE13)
    stack_err = sp_load_i & (sp_value_i > stack_limit_value | sp_value_i < tvu_pkg::STACK_FLOOR); // (RULE21)
    lockout = (math_err & addr_err) | (math_err & stack_err) | (addr_err & stack_err); // (RULE9)
    next_reset = watchdog_timeout_i | uninit_w_ptr_i | lockout // (RULE6) (RULE7)
               | (illegal_op_exec_i & ~illegal_op_flushed_i); // (RULE8)
  end

  // pending traps held until the instruction completes
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      math_pend  <= 1'b0;
      addr_pend  <= 1'b0;
      stack_pend <= 1'b0;
    end else begin
      math_pend  <= math_err | (math_pend & ~(trap_o & trap_level_o == tvu_pkg::LVL_MATH));
      addr_pend  <= addr_err | (addr_pend & ~(trap_o & trap_level_o == tvu_pkg::LVL_ADDR));
      stack_pend <= stack_err | (stack_pend & ~(trap_o & trap_level_o == tvu_pkg::LVL_STACK));
    end
  end

  // trap dispatch; nesting allowed, highest pending level first
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      state               <= tvu_pkg::TVU_RUN;
      trap_o              <= 1'b0;
      trap_level_o        <= 4'h0;
      trap_vec_addr_o     <= tvu_pkg::RESET_ADDR;
      in_trap             <= 1'b0;
      cur_trap_lvl        <= 4'h0;
      trap_priority_bit_o <= 1'b0;
    end else begin
      trap_o <= 1'b0;
      unique case (state)
        tvu_pkg::TVU_RUN: begin
          if ((math_pend | addr_pend | stack_pend) && instr_done_i) begin // (RULE12) (RULE14)
            trap_o <= 1'b1;
            trap_level_o <= stack_pend ? tvu_pkg::LVL_STACK :
                            addr_pend ? tvu_pkg::LVL_ADDR : tvu_pkg::LVL_MATH; // (RULE10)
            trap_vec_addr_o <= tvu_pkg::VT_FIRST + tvu_pkg::VT_STRIDE *
                               {20'h00000, (stack_pend ? tvu_pkg::LVL_STACK :
                               addr_pend ? tvu_pkg::LVL_ADDR : tvu_pkg::LVL_MATH) - 4'h8}; // (RULE25) (RULE23)
            in_trap <= 1'b1;
            cur_trap_lvl <= stack_pend ? tvu_pkg::LVL_STACK :
                            addr_pend ? tvu_pkg::LVL_ADDR : tvu_pkg::LVL_MATH;
            trap_priority_bit_o <= 1'b1; // (RULE10)
            state <= tvu_pkg::TVU_TRAP_WAIT;
          end else if (in_trap && cpu_priority_level_i[tvu_pkg::TRAP_BIT] == 1'b0) begin
            in_trap <= 1'b0;
            trap_priority_bit_o <= 1'b0;
          end
        end
        tvu_pkg::TVU_TRAP_WAIT: begin
          state <= tvu_pkg::TVU_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt request to core
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin // (RULE5)
      irq_o        <= 1'b0;
      irq_vector_o <= 7'h00;
      irq_level_o  <= 4'h0;
    end else begin
      irq_o        <= res_any && !in_trap && {1'b0, res_lvl} > cpu_priority_level_i
                      && cpu_priority_level_i != tvu_pkg::IPL_MASK_ALL; // (RULE11)
      irq_vector_o <= {1'b0, res_src} + tvu_pkg::VEC_OFFSET; // (RULE1)
      irq_level_o  <= {1'b0, res_lvl};
    end
  end

  // reset entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b0;
      reset_pc_o   <= tvu_pkg::RESET_ADDR; // (RULE5)
    end else begin
      core_reset_o <= next_reset & ~core_reset_o; // (RULE6)
      reset_pc_o   <= tvu_pkg::RESET_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      unique case (wb_adr_i[5:2])
        tvu_pkg::REG_CTRL:      wb_dat_o <= {16'h0000, ctrl};
        tvu_pkg::REG_STATUS:    wb_dat_o <= {28'h0000000, err_sticky};
        tvu_pkg::REG_STACK_LIM: wb_dat_o <= {16'h0000, stack_limit_value};
        tvu_pkg::REG_VECTOR:    wb_dat_o <= {21'h000000, irq_level_o, irq_vector_o};
        default:                wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl              <= 16'h0000;
      stack_limit_value <= tvu_pkg::STACK_LIM_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      if (wb_adr_i[5:2] == tvu_pkg::REG_CTRL) begin
        if (wb_sel_i[0]) ctrl[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) ctrl[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i[5:2] == tvu_pkg::REG_STACK_LIM) begin
        if (wb_sel_i[0]) stack_limit_value[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) stack_limit_value[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // sticky errors: set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_sticky <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if ((wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[5:2] == tvu_pkg::REG_STATUS
             && wb_sel_i[0] && wb_dat_i[i]))
          err_sticky[i] <= 1'b0;
      end
      if (math_err)   err_sticky[0] <= 1'b1;
      if (addr_err)   err_sticky[1] <= 1'b1;
      if (stack_err)  err_sticky[2] <= 1'b1;
      if (next_reset) err_sticky[3] <= 1'b1;
    end
  end
endmodule : tvu_top

// [logic/tvu_pkg.sv]
// package of constants for the trap and vector unit
package tvu_pkg;
  // source and vector numbering
  localparam int          NUM_SRC         = 54;
  localparam int          SRC_W           = 6;
  localparam int          VEC_W           = 7;
  localparam logic [6:0]  VEC_OFFSET      = 7'h08;
  localparam logic [5:0]  SRC_EXT0        = 6'h00;
  localparam logic [5:0]  SRC_EXT1        = 6'h10;
  localparam logic [5:0]  SRC_EXT2        = 6'h11;
  localparam logic [5:0]  SRC_PWM_FIRST   = 6'h12;
  localparam logic [5:0]  SRC_PWM_LAST    = 6'h16;
  localparam logic [5:0]  SRC_PAIR_FIRST  = 6'h25;
  localparam logic [5:0]  SRC_PAIR_LAST   = 6'h2A;
  // reserved sources: 4,15,23-26,28,33-36,43-53
  localparam logic [53:0] SRC_RESERVED    = 54'h3FF81E17808010;
  // program memory map
  localparam int          PA_W            = 24;
  localparam logic [23:0] RESET_ADDR      = 24'h000000;
  localparam logic [23:0] VT_FIRST        = 24'h000004;
  localparam logic [23:0] VT_LAST         = 24'h0000FE;
  localparam logic [23:0] VT_STRIDE       = 24'h000002;
  // priority levels
  localparam logic [3:0]  IPL_MASK_ALL    = 4'h7;
  localparam logic [3:0]  LVL_MATH        = 4'hB;
  localparam logic [3:0]  LVL_ADDR        = 4'hC;
  localparam logic [3:0]  LVL_STACK       = 4'hD;
  localparam int          TRAP_BIT        = 3;
  // stack floor
  localparam logic [15:0] STACK_FLOOR     = 16'h0800;
  // accumulator bits
  localparam int          ACC_OV_BIT      = 31;
  localparam int          ACC_COV_BIT     = 39;
  // register map over wishbone (word addresses, byte address = 4*index)
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h1;
  localparam logic [3:0]  REG_STACK_LIM   = 4'h2;
  localparam logic [3:0]  REG_VECTOR      = 4'h3;
  // ctrl fields
  localparam int          CTRL_OV_EN      = 0;
  localparam int          CTRL_COV_EN     = 1;
  localparam int          CTRL_SAT_EN     = 2;
  localparam int          CTRL_GUARD_USE  = 3;
  localparam logic [15:0] STACK_LIM_RST   = 16'hFFFE;
  typedef enum logic [1:0] {TVU_RUN, TVU_TRAP_WAIT} tvu_state_e;
endpackage : tvu_pkg

// [logic/tvu_src_resolver.sv]
// natural order priority resolver for interrupt sources
`timescale 1ns/1ps
module tvu_src_resolver (
  // requests with levels
  input  wire logic [53:0]  req_i,
  input  wire logic [161:0] lvl_i,
  // result
  output logic              any_o,
  output logic [5:0]        src_o,
  output logic [2:0]        lvl_o
);
  logic [53:0] live;

  genvar g;
  generate
    for (g = 0; g < tvu_pkg::NUM_SRC; g++) begin : g_tie
      assign live[g] = req_i[g] & ~tvu_pkg::SRC_RESERVED[g]; // (RULE24)
    end
  endgenerate

  // highest level wins, lowest number among equals
  always_comb begin
    any_o = 1'b0;
    src_o = 6'h00;
    lvl_o = 3'h0;
    for (int i = tvu_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (live[i] && lvl_i[i*3 +: 3] != 3'h0 && (!any_o || lvl_i[i*3 +: 3] >= lvl_o)) begin // (RULE22)
        any_o = 1'b1;
        src_o = i[5:0];
        lvl_o = lvl_i[i*3 +: 3];
      end
    end
  end
endmodule : tvu_src_resolver

// [verification/tvu_core_model.sv]
// core model: instruction completion strobe, prompt or slow
`timescale 1ns/1ps
module tvu_core_model (
  // clock, reset and pace
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  // completion strobe
  output logic      instr_done_o
);
  logic [1:0] cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt == 2'h2) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  // slow pace completes one instruction in three cycles
  assign instr_done_o = !rst_i && (!slow_i || cnt == 2'h2);
endmodule : tvu_core_model

// [verification/tvu_top_props.sv]
// assertion checker on the trap and vector unit ports
`timescale 1ns/1ps
module tvu_top_props (
  // watched ports
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, instr_done_i,
  input wire logic        div_zero_i, data_misaligned_i, watchdog_timeout_i, uninit_w_ptr_i,
  input wire logic        irq_o, trap_o, core_reset_o,
  input wire logic [3:0]  cpu_priority_level_i, trap_level_o,
  input wire logic [6:0]  irq_vector_o,
  input wire logic [23:0] trap_vec_addr_o, reset_pc_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_div; div_zero_i && !data_misaligned_i ##1 instr_done_i; endsequence
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_pc; reset_pc_o == tvu_pkg::RESET_ADDR; endproperty
  property p_lvl; trap_o |-> trap_level_o[3]; endproperty
  property p_vec; trap_o |-> trap_vec_addr_o == 24'h4 + {19'h0, trap_level_o - 4'h8, 1'b0}; endproperty
  property p_irq; irq_o |-> irq_vector_o >= 7'h08 && !tvu_pkg::SRC_RESERVED[irq_vector_o - 7'h08]; endproperty
  property p_mask; cpu_priority_level_i == tvu_pkg::IPL_MASK_ALL |=> !irq_o; endproperty
  property p_lock; div_zero_i && data_misaligned_i |=> core_reset_o; endproperty
  property p_wdt; watchdog_timeout_i |=> core_reset_o; endproperty
  property p_uninit; uninit_w_ptr_i |=> core_reset_o; endproperty
  property p_done; trap_o |-> $past(instr_done_i); endproperty
  property p_div; s_div |=> trap_o && trap_level_o == tvu_pkg::LVL_MATH; endproperty
  a_ack: assert property (p_ack) else $error("wishbone ack late");
  a_pc: assert property (p_pc) else $error("reset entry not zero");
  a_lvl: assert property (p_lvl) else $error("trap level below eight");
  a_vec: assert property (p_vec) else $error("trap vector address wrong");
  a_irq: assert property (p_irq) else $error("irq vector out of map");
  a_mask: assert property (p_mask) else $error("irq not masked at level seven");
  a_lock: assert property (p_lock) else $error("no reset on trap lockout");
  a_wdt: assert property (p_wdt) else $error("no reset on watchdog");
  a_uninit: assert property (p_uninit) else $error("no reset on bad pointer");
  a_done: assert property (p_done) else $error("trap before instruction end");
  a_div: assert property (p_div) else $error("divide by zero not trapped");
endmodule : tvu_top_props
bind tvu_top tvu_top_props u_props (.*);

// [verification/testbench.sv]
// self-checking bench for the trap and vector unit
`timescale 1ns/1ps
module testbench;
  logic         clk_i, rst_i, cyc, stb, we, ack, slow, done, trap_o, tbit, core_reset_o, irq_o;
  logic [5:0]   adr;
  logic [31:0]  wdat, rdat, rd;
  logic [53:0]  src;
  logic [161:0] lvls;
  logic [14:0]  ev;
  logic [15:0]  sp;
  logic [3:0]   cpu_priority_level, tlvl, ilvl;
  logic [6:0]   ivec;
  logic [23:0]  tvec, rpc;
  int           num_errors, compares, cyc_n;
  int           itab [20] = '{0, 16, 17, 18, 19, 20, 21, 22, 37, 38, 39, 40, 41, 42, 1, 27, 4, 23, 43, 53};
  // {reset expected, event bits} level sp value
  logic [35:0]  ttab [19] = '{36'h0001_B_0000, 36'h0002_B_0000, 36'h1000_B_0000, 36'h0004_B_0000,
    36'h0008_C_0000, 36'h0010_C_0000, 36'h0020_C_0000, 36'h0040_C_0000, 36'h2000_C_0000, 36'h4000_C_0000,
    36'h0080_D_07FE, 36'h0080_D_0A00, 36'h0080_0_0800, 36'h0080_0_0900, 36'h8100_0_0000,
    36'h8200_0_0000, 36'h8400_0_0000, 36'h0C00_0_0000, 36'h8009_0_0000};
  tvu_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .instr_done_o(done));
  tvu_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_request_0_i(src[0]), .ext_request_1_i(src[16]), .ext_request_2_i(src[17]),
    .pwm_event_i(src[22:18]), .pair_done_i(src[42:37]), .other_req_i(src), .src_level_i(lvls),
    .instr_done_i(done), .cpu_priority_level_i(cpu_priority_level), .div_zero_i(ev[0]), .acc_carry31_i(ev[1]),
    .shift_too_big_i(ev[2]), .data_misaligned_i(ev[3]), .data_unimpl_i(ev[4]), .prog_data_unimpl_i(ev[5]),
    .fetch_valid_i(ev[6]), .sp_load_i(ev[7]), .watchdog_timeout_i(ev[8]), .uninit_w_ptr_i(ev[9]),
    .illegal_op_exec_i(ev[10]), .illegal_op_flushed_i(ev[11]), .acc_carry39_i(ev[12]),
    .mac_dual_i(ev[13]), .mac_cross_space_i(ev[13]), .handler_valid_i(ev[14]),
    .fetch_addr_i(24'h000010), .vector_fetch_i(1'b0), .prog_limit_i(24'h001FFF),
    .handler_addr_i(24'h000010), .sp_value_i(sp), .irq_o(irq_o), .irq_vector_o(ivec), .irq_level_o(ilvl),
    .trap_o(trap_o), .trap_level_o(tlvl), .trap_vec_addr_o(tvec), .trap_priority_bit_o(tbit),
    .core_reset_o(core_reset_o), .reset_pc_o(rpc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic run(input logic [35:0] t);
    logic ts, rs;
    logic [3:0] lv;
    logic [23:0] va;
    ts = 0; rs = 0; lv = 0; va = 0;
    sp <= t[15:0]; ev <= t[34:20];
    @(posedge clk_i);
    ev <= '0;
    repeat (12) begin
      @(posedge clk_i);
      if (trap_o === 1'b1) begin ts = 1; lv = tlvl; va = tvec; end
      rs = rs | (core_reset_o === 1'b1);
    end
    chk("trap_o", 32'(t[19:16] != 0), 32'(ts));
    chk("core_reset_o", 32'(t[35]), 32'(rs));
    if (t[19:16] != 0) begin
      chk("trap_level_o", 32'(t[19:16]), 32'(lv));
      chk("trap_vec_addr_o", 32'(4 + 2 * (int'(t[19:16]) - 8)), 32'(va));
      chk("trap_priority_bit_o", 32'h1, 32'(tbit));
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin num_errors++; print_verdict(); end
  end
  initial begin
    rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; src = 0; lvls = {54{3'h1}};
    ev = 0; sp = 0; cpu_priority_level = 0; slow = 0; num_errors = 0; compares = 0; cyc_n = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 6'h08, 0); chk("stack_lim", 32'h0000FFFE, rd);
    wb(0, 6'h00, 0); chk("ctrl", 32'h0, rd);
    wb(1, 6'h00, 32'h3); wb(0, 6'h00, 0); chk("ctrl", 32'h3, rd);
    wb(1, 6'h14, 32'hFFFF); wb(0, 6'h14, 0); chk("unmapped", 32'h0, rd);
    wb(1, 6'h08, 32'h0900);
    foreach (itab[i]) begin
      src <= 54'h1 << itab[i];
      repeat (3) @(posedge clk_i);
      chk("irq_o", 32'(!tvu_pkg::SRC_RESERVED[itab[i]]), 32'(irq_o));
      if (!tvu_pkg::SRC_RESERVED[itab[i]]) chk("irq_vector_o", 32'(itab[i] + 8), 32'(ivec));
    end
    src <= (54'h1 << 16) | (54'h1 << 37);
    repeat (3) @(posedge clk_i);
    wb(0, 6'h0C, 0); chk("vector", 32'h98, rd);
    lvls[113:111] <= 3'h2;
    repeat (3) @(posedge clk_i);
    chk("irq_vector_o", 32'd45, 32'(ivec));
    chk("irq_level_o", 32'h2, 32'(ilvl));
    cpu_priority_level <= 4'h7;
    repeat (3) @(posedge clk_i);
    chk("irq_o", 32'h0, 32'(irq_o));
    cpu_priority_level <= 4'h8; src <= '0;
    foreach (ttab[i]) begin
      slow <= i[0];
      run(ttab[i]);
    end
    run(ttab[0]);
    cpu_priority_level <= 4'h0;
    repeat (3) @(posedge clk_i);
    chk("trap_priority_bit_o", 32'h0, 32'(tbit));
    wb(0, 6'h04, 0); chk("status", 32'hF, rd);
    wb(1, 6'h04, 32'hF); wb(0, 6'h04, 0); chk("status", 32'h0, rd);
    print_verdict();
  end
endmodule : testbench
